// [core/ppl_pkg.sv]
// Package of constants and types for the per-lane PIPE MAC interface
package ppl_pkg;

  // ****************************************************************
  // Rate and power encodings
  // ****************************************************************
  localparam logic [1:0] RATE_GEN1 = 2'h0;
  localparam logic [1:0] RATE_GEN2 = 2'h1;
  localparam logic [1:0] RATE_GEN3 = 2'h2;
  localparam logic [1:0] PWR_P0 = 2'h0;
  localparam logic [1:0] PWR_P0S = 2'h1;
  localparam logic [1:0] PWR_P1 = 2'h2;
  localparam logic [1:0] PWR_P2 = 2'h3;

  // ****************************************************************
  // Idle inference select encodings
  // ****************************************************************
  localparam logic [2:0] IIS_NONE = 3'h0;
  localparam logic [2:0] IIS_COM_SKP = 3'h4;
  localparam logic [2:0] IIS_TS = 3'h5;
  localparam logic [2:0] IIS_EIEXIT_UI = 3'h6;
  localparam logic [2:0] IIS_EIEXIT_US = 3'h7;

  // ****************************************************************
  // Field layout and widths
  // ****************************************************************
  localparam int COEF_W = 18;
  localparam int PRE_LSB = 0;
  localparam int MAIN_LSB = 6;
  localparam int POST_LSB = 12;
  localparam int CUR_W = 6;
  localparam int PRESET_W = 3;
  localparam int DW_GEN12 = 8;
  localparam int DW_GEN3 = 32;
  localparam int RX_W = 32;
  localparam int K_W = 4;
  localparam int LANES_MAX = 8;

  // ****************************************************************
  // Memory-mapped register map (word offsets as byte addresses)
  // ****************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_COEF = 8'h04;
  localparam logic [7:0] REG_PRESET = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [31:0] UNMAPPED_RD = 32'h0;

  // CTRL fields
  localparam int C_PWR_LSB = 0;
  localparam int C_RATE_LSB = 2;
  localparam int C_IIS_LSB = 4;
  localparam int C_INV_LSB = 8;
  localparam int C_GO_BIT = 31;

  // Reset values
  localparam logic [1:0] RST_PWR = PWR_P1;
  localparam logic [1:0] RST_RATE = RATE_GEN1;
  localparam logic [2:0] RST_IIS = IIS_NONE;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT} ppl_req_t;

endpackage : ppl_pkg

// [core/ppl_lane_ctrl.sv]
// PIPE MAC-side per-lane control with a memory-mapped register slave
// Operation
// - Data path is 8 bits at gen1/gen2, 32 bits at gen3.
// - Every lane-zero signal except the invert request is replicated for lanes one to seven; invert is set per lane.
// - 18-bit coefficient word: pre [5:0], main [11:6], post [17:12].
// - Current receiver preset driven on a 3-bit per-lane output.
// - Idle inference select top bit zero when no inference needed.
// - Select 100: no COM/SKP within 128 us at gen1/gen2.
// - Select 101: no TS1/TS2 within 1280 UI at gen1/gen2.
// - Select 110: no idle exit in 2000 UI gen1, 16000 UI gen2.
// - Select 111: no idle exit within 128 us at gen1.
// - Power state request is a 2-bit per-lane field.
// - Rate select 00/01/10; value 11 is never driven.
// - Invert request makes PHY invert polarity into its decoder.
// - Interface is for simulation and debug only, not hardware.
// - Gen3 equalization phases 2 and 3 are done when directed; this block has no phase control and the PHY model skips them.
`timescale 1ns/1ns
`default_nettype none

module ppl_lane_ctrl #(
  parameter int LANES = ppl_pkg::LANES_MAX
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] avm_address_i,
  input wire logic avm_read_i,
  input wire logic avm_write_i,
  input wire logic [31:0] avm_writedata_i,
  input wire logic [3:0] avm_byteenable_i,
  output logic [31:0] avm_readdata_o,
  output logic avm_waitrequest_o,
  output logic [LANES*ppl_pkg::COEF_W-1:0] tx_equalizer_coefficients_o,
  output logic [LANES*ppl_pkg::PRESET_W-1:0] active_receiver_preset_o,
  output logic [LANES*3-1:0] idle_inference_select_o,
  output logic [LANES*2-1:0] power_state_request_o,
  output logic [1:0] rate_o,
  output logic [LANES-1:0] receive_invert_request_o,
  output logic [5:0] data_width_o,
  input wire logic [LANES-1:0] phy_request_done_i,
  input wire logic [LANES-1:0] receive_block_start_i,
  input wire logic [LANES*ppl_pkg::RX_W-1:0] lane_receive_bus_i,
  input wire logic [LANES*ppl_pkg::K_W-1:0] receive_control_byte_flags_i,
  input wire logic [LANES-1:0] receive_idle_detected_i
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  // Reserved rate code folds back to gen1 so 11 never reaches the pins
  function automatic logic [1:0] legal_rate(input logic [1:0] r);
    legal_rate = (r == 2'h3) ? ppl_pkg::RATE_GEN1 : r;
  endfunction : legal_rate

  // Data width for a given rate
  function automatic logic [5:0] width_of(input logic [1:0] r);
    width_of = (r == ppl_pkg::RATE_GEN3) ? 6'(ppl_pkg::DW_GEN3)
      : 6'(ppl_pkg::DW_GEN12);
  endfunction : width_of

  // ****************************************************************
  // Register state
  // ****************************************************************
  // Sim/debug only path, no serializer model behind it
  logic [1:0] pwr_req, next_pwr_req;
  logic [1:0] rate_req, next_rate_req;
  logic [2:0] iis, next_iis;
  logic [LANES-1:0] inv, next_inv;
  logic [ppl_pkg::COEF_W-1:0] coef, next_coef;
  logic [ppl_pkg::PRESET_W-1:0] preset, next_preset;
  logic [31:0] rdata, next_rdata;
  logic wait_q, next_wait_q;
  ppl_pkg::ppl_req_t st, next_st;
  logic [LANES-1:0] done_seen, next_done_seen;
  logic busy_wr;

  // Any CTRL write, with or without GO, while a request is pending is held off
  assign busy_wr = (st == ppl_pkg::ST_WAIT) && avm_write_i &&
    (avm_address_i == ppl_pkg::REG_CTRL);

  // Bus slave: one wait cycle, then answer
  always_comb
  begin
    next_pwr_req = pwr_req;
    next_rate_req = rate_req;
    next_iis = iis;
    next_inv = inv;
    next_coef = coef;
    next_preset = preset;
    next_rdata = rdata;
    next_wait_q = 1'b1;
    if ((avm_read_i || avm_write_i) && wait_q && !busy_wr)
      next_wait_q = 1'b0;
    if (avm_write_i && !wait_q)
    begin
      unique case (avm_address_i)
        ppl_pkg::REG_CTRL:
        begin
          next_pwr_req = avm_writedata_i[ppl_pkg::C_PWR_LSB +: 2];
          next_rate_req =
            legal_rate(avm_writedata_i[ppl_pkg::C_RATE_LSB +: 2]);
          next_iis = avm_writedata_i[ppl_pkg::C_IIS_LSB +: 3];
          next_inv = avm_writedata_i[ppl_pkg::C_INV_LSB +: LANES];
        end
        ppl_pkg::REG_COEF:
          next_coef = avm_writedata_i[ppl_pkg::COEF_W-1:0];
        ppl_pkg::REG_PRESET:
          next_preset = avm_writedata_i[ppl_pkg::PRESET_W-1:0];
        default:
          next_rdata = rdata;
      endcase
    end
    if (avm_read_i && wait_q)
    begin
      unique case (avm_address_i)
        ppl_pkg::REG_CTRL:
        begin
          next_rdata = 32'h0;
          next_rdata[ppl_pkg::C_PWR_LSB +: 2] = pwr_req;
          next_rdata[ppl_pkg::C_RATE_LSB +: 2] = rate_req;
          next_rdata[ppl_pkg::C_IIS_LSB +: 3] = iis;
          next_rdata[ppl_pkg::C_INV_LSB +: LANES] = inv;
        end
        ppl_pkg::REG_COEF:
          next_rdata = 32'(coef);
        ppl_pkg::REG_PRESET:
          next_rdata = 32'(preset);
        ppl_pkg::REG_STATUS:
        begin
          next_rdata = 32'h0;
          next_rdata[LANES-1:0] = receive_idle_detected_i;
          next_rdata[8 +: LANES] = done_seen;
          next_rdata[16] = (st == ppl_pkg::ST_WAIT);
        end
        default:
          next_rdata = ppl_pkg::UNMAPPED_RD;
      endcase
    end
  end

  // Register bank
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pwr_req <= ppl_pkg::RST_PWR;
      rate_req <= ppl_pkg::RST_RATE;
      iis <= ppl_pkg::RST_IIS;
      inv <= '0;
      coef <= '0;
      preset <= '0;
      rdata <= 32'h0;
      wait_q <= 1'b1;
    end
    else
    begin
      pwr_req <= next_pwr_req;
      rate_req <= next_rate_req;
      iis <= next_iis;
      inv <= next_inv;
      coef <= next_coef;
      preset <= next_preset;
      rdata <= next_rdata;
      wait_q <= next_wait_q;
    end
  end

  // ****************************************************************
  // Request handshake: hold until every lane reports done
  // ****************************************************************
  logic ctrl_commit;
  assign ctrl_commit = avm_write_i && !wait_q &&
    (avm_address_i == ppl_pkg::REG_CTRL) &&
    avm_writedata_i[ppl_pkg::C_GO_BIT];

  always_comb
  begin
    next_st = st;
    next_done_seen = done_seen;
    unique case (st)
      ppl_pkg::ST_IDLE:
        if (ctrl_commit)
        begin
          next_st = ppl_pkg::ST_WAIT;
          next_done_seen = '0;
        end
      ppl_pkg::ST_WAIT:
      begin
        next_done_seen = done_seen | phy_request_done_i;
        if (&next_done_seen)
          next_st = ppl_pkg::ST_IDLE;
      end
      default:
        next_st = ppl_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st <= ppl_pkg::ST_IDLE;
      done_seen <= '0;
    end
    else
    begin
      st <= next_st;
      done_seen <= next_done_seen;
    end
  end

  // ****************************************************************
  // Per-lane outputs, lane zero replicated across lanes except invert, which is set per lane
  // ****************************************************************
  logic [LANES*ppl_pkg::COEF_W-1:0] next_coef_o;
  logic [LANES*ppl_pkg::PRESET_W-1:0] next_preset_o;
  logic [LANES*3-1:0] next_iis_o;
  logic [LANES*2-1:0] next_pwr_o;
  logic [1:0] next_rate_o;

  // Lane fan-out of shared settings
  always_comb
  begin
    for (int l = 0; l < LANES; l++)
    begin
      next_coef_o[l*ppl_pkg::COEF_W +: ppl_pkg::COEF_W] = coef;
      next_preset_o[l*ppl_pkg::PRESET_W +: ppl_pkg::PRESET_W] = preset;
      next_iis_o[l*3 +: 3] = iis;
      // The value being written goes out, not the one it replaces
      next_pwr_o[l*2 +: 2] = tx_hold(st, next_pwr_req,
        power_state_request_o[l*2 +: 2]);
    end
    next_rate_o = tx_hold(st, next_rate_req, rate_o);
  end

  // Power and rate pins change only once a request has been launched
  function automatic logic [1:0] tx_hold(input ppl_pkg::ppl_req_t s,
    input logic [1:0] want, input logic [1:0] cur);
    tx_hold = (s == ppl_pkg::ST_IDLE && ctrl_commit) ? want : cur;
  endfunction : tx_hold

  // Output registers
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tx_equalizer_coefficients_o <= '0;
      active_receiver_preset_o <= '0;
      idle_inference_select_o <= '0;
      power_state_request_o <= {LANES{ppl_pkg::RST_PWR}};
      rate_o <= ppl_pkg::RST_RATE;
      receive_invert_request_o <= '0;
      data_width_o <= 6'(ppl_pkg::DW_GEN12);
    end
    else
    begin
      tx_equalizer_coefficients_o <= next_coef_o;
      active_receiver_preset_o <= next_preset_o;
      idle_inference_select_o <= next_iis_o;
      power_state_request_o <= next_pwr_o;
      rate_o <= next_rate_o;
      receive_invert_request_o <= inv;
      data_width_o <= width_of(next_rate_o);
    end
  end

  assign avm_readdata_o = rdata;
  assign avm_waitrequest_o = wait_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_launch;
    st == ppl_pkg::ST_IDLE && ctrl_commit;
  endsequence

  a_rate_legal: assert property (@(posedge clk_i) disable iff (rst_i)
    rate_o != 2'h3) else $error("reserved rate driven");
  a_width_rate: assert property (@(posedge clk_i) disable iff (rst_i)
    data_width_o == ((rate_o == ppl_pkg::RATE_GEN3) ? 6'h20 : 6'h08))
    else $error("data width mismatches rate");
  a_req_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    st == ppl_pkg::ST_WAIT |=> $stable(rate_o) &&
    $stable(power_state_request_o))
    else $error("request changed before done");
  a_launch_wait: assert property (@(posedge clk_i) disable iff (rst_i)
    s_launch |=> st == ppl_pkg::ST_WAIT)
    else $error("request not launched");
  a_lane_copy: assert property (@(posedge clk_i) disable iff (rst_i)
    idle_inference_select_o[LANES*3-1 -: 3] == idle_inference_select_o[2:0])
    else $error("lanes differ");
  a_coef_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 tx_equalizer_coefficients_o[17:0] == $past(coef))
    else $error("coefficient word lags");
  a_preset_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 active_receiver_preset_o[2:0] == $past(preset))
    else $error("preset lags");
  a_inv_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 receive_invert_request_o == $past(inv)) else $error("invert lags");
  a_pwr_launch: assert property (@(posedge clk_i) disable iff (rst_i)
    s_launch |=> power_state_request_o[1:0] == pwr_req)
    else $error("power request not driven");

endmodule : ppl_lane_ctrl

`default_nettype wire

// [dv/ppl_phy_model.sv]
// Behavioural PHY model at the far side of the lane control block
`timescale 1ns/1ns
`default_nettype none

module ppl_phy_model #(
  parameter int LANES = 2,
  parameter int DLY = 20
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [LANES*2-1:0] power_state_request_i,
  input wire logic [1:0] rate_i,
  input wire logic [LANES-1:0] receive_invert_request_i,
  input wire logic [LANES-1:0] idle_i,
  output logic [LANES-1:0] phy_request_done_o,
  output logic [LANES-1:0] receive_block_start_o,
  output logic [LANES*32-1:0] lane_receive_bus_o,
  output logic [LANES*4-1:0] receive_control_byte_flags_o,
  output logic [LANES-1:0] receive_idle_detected_o
);
  logic [LANES*2+1:0] last, next_last;
  logic [LANES-1:0] next_done;
  logic [7:0] cnt, next_cnt;
  logic [31:0] pat, next_pat;

  // ****************************************************************
  // Request completion
  // ****************************************************************
  // Lane i answers DLY+i+1 cycles after a power or rate change
  // Equalization phases 2 and 3 are skipped by this model
  always_comb
  begin
    next_last = {rate_i, power_state_request_i};
    next_cnt = (cnt != 8'h0) ? cnt + 8'h1 : 8'h0;
    next_pat = pat + 32'h9e37; // Receive data changes every cycle
    if (next_last != last)
      next_cnt = 8'h1;
    else if (cnt == 8'(DLY + LANES))
      next_cnt = 8'h0;
    for (int i = 0; i < LANES; i++)
      next_done[i] = (cnt == 8'(DLY + i));
  end

  // Registers of the completion timer
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      last <= {ppl_pkg::RST_RATE, {LANES{ppl_pkg::RST_PWR}}};
      cnt <= 8'h0;
      pat <= 32'h0;
      phy_request_done_o <= '0;
    end
    else
    begin
      last <= next_last;
      cnt <= next_cnt;
      pat <= next_pat;
      phy_request_done_o <= next_done;
    end
  end

  // ****************************************************************
  // Receive path
  // ****************************************************************
  // Per-lane data, byte flags, block start and idle detection
  always_comb
  begin
    for (int i = 0; i < LANES; i++)
    begin
      lane_receive_bus_o[i*32 +: 32] =
        pat ^ {32{receive_invert_request_i[i]}};
      receive_control_byte_flags_o[i*4 +: 4] =
        (rate_i == ppl_pkg::RATE_GEN3) ? 4'h0 : pat[3:0];
      receive_block_start_o[i] =
        (rate_i == ppl_pkg::RATE_GEN3) && (pat[1:0] == 2'h0);
    end
    receive_idle_detected_o = idle_i;
  end
endmodule : ppl_phy_model
`default_nettype wire

// [dv/pcie_pipe_mac_lane_interface_tb_top.sv]
// Testbench of the per-lane PIPE MAC control block
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end

module pcie_pipe_mac_lane_interface_tb_top;
  localparam int LANES = 2;
  logic clk_i, rst_i, rd, wr;
  logic [7:0] addr;
  logic [31:0] wdata, q;
  logic [LANES-1:0] idle;
  int n_errors = 0;
  int checks = 0;
  int nw;
  wire logic [31:0] rdata;
  wire logic wait_req;
  wire logic [LANES*18-1:0] coef;
  wire logic [LANES*3-1:0] preset, iis;
  wire logic [LANES*2-1:0] pwr;
  wire logic [1:0] rate;
  wire logic [LANES-1:0] inv, done, blk, rxidle;
  wire logic [5:0] dw;
  wire logic [LANES*32-1:0] rxd;
  wire logic [LANES*4-1:0] rxk;
  logic [2:0] codes [5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};
  logic [1:0] tp [4] = '{2'h0, 2'h1, 2'h3, 2'h0};
  logic [1:0] tr [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
  logic [1:0] er;

  // ****************************************************************
  // Design, far side and clock
  // ****************************************************************
  ppl_lane_ctrl #(.LANES(LANES)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
    .avm_address_i(addr), .avm_read_i(rd), .avm_write_i(wr),
    .avm_writedata_i(wdata), .avm_byteenable_i(4'hf),
    .avm_readdata_o(rdata), .avm_waitrequest_o(wait_req),
    .tx_equalizer_coefficients_o(coef), .active_receiver_preset_o(preset),
    .idle_inference_select_o(iis), .power_state_request_o(pwr),
    .rate_o(rate), .receive_invert_request_o(inv), .data_width_o(dw),
    .phy_request_done_i(done), .receive_block_start_i(blk),
    .lane_receive_bus_i(rxd), .receive_control_byte_flags_i(rxk),
    .receive_idle_detected_i(rxidle));
  ppl_phy_model #(.LANES(LANES), .DLY(20)) u_phy (.clk_i(clk_i),
    .rst_i(rst_i), .power_state_request_i(pwr), .rate_i(rate),
    .receive_invert_request_i(inv), .idle_i(idle),
    .phy_request_done_o(done), .receive_block_start_o(blk),
    .lane_receive_bus_o(rxd), .receive_control_byte_flags_o(rxk),
    .receive_idle_detected_o(rxidle));

  // Free-running 125 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // ****************************************************************
  // Bus tasks
  // ****************************************************************
  // One register access; holds the request until waitrequest is low
  task automatic av(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r, output int n);
    n = 0;
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    rd <= !w;
    wr <= w;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (wait_req !== 1'b0 && n < 2000);
    r = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 2000)
      n_errors++;
  endtask : av

  // Control word: go, idle select, rate, power, invert
  function automatic logic [31:0] ctrl(input logic go, input logic [2:0] s,
    input logic [1:0] r, input logic [1:0] p, input logic [LANES-1:0] v);
    return {go, 31'h0} | (32'(v) << 8) | {25'h0, s, r, p};
  endfunction : ctrl

  // Prints the counts and the verdict, then stops
  task automatic end_sim();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim

  // Watchdog against a hung handshake
  initial
  begin
    repeat (5000) @(posedge clk_i);
    n_errors++;
    end_sim();
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    rst_i = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    idle = '0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    `CHK("pwr", {LANES{ppl_pkg::PWR_P1}}, pwr)
    `CHK("rate", ppl_pkg::RATE_GEN1, rate)
    `CHK("width", 6'h08, dw)
    $display("test reset done");
    av(1'b1, ppl_pkg::REG_COEF, 32'h00029c45, q, nw);
    av(1'b1, ppl_pkg::REG_PRESET, 32'h00000005, q, nw);
    repeat (2) @(posedge clk_i);
    `CHK("coef", {LANES{18'h29c45}}, coef)
    `CHK("main", 6'h31, coef[18+ppl_pkg::MAIN_LSB +: 6])
    `CHK("preset", {LANES{3'h5}}, preset)
    $display("test equalizer done");
    for (int i = 0; i < 5; i++)
    begin
      av(1'b1, ppl_pkg::REG_CTRL, ctrl(1'b0, codes[i], 2'h2, 2'h0,
        LANES'(i)), q, nw);
      repeat (2) @(posedge clk_i);
      `CHK("iis", {LANES{codes[i]}}, iis)
      `CHK("invert", LANES'(i), inv)
      `CHK("pwr held", {LANES{ppl_pkg::PWR_P1}}, pwr)
    end
    $display("test idle select done");
    for (int i = 0; i < 4; i++)
    begin
      er = (tr[i] == 2'h3) ? ppl_pkg::RATE_GEN1 : tr[i];
      av(1'b1, ppl_pkg::REG_CTRL, ctrl(1'b1, 3'h0, tr[i], tp[i], '0), q, nw);
      repeat (2) @(posedge clk_i);
      `CHK("pwr", {LANES{tp[i]}}, pwr)
      `CHK("rate", er, rate)
      `CHK("width", (er == 2'h2) ? 6'h20 : 6'h08, dw)
      av(1'b0, ppl_pkg::REG_STATUS, 32'h0, q, nw);
      `CHK("busy", 1'b1, q[16])
      av(1'b1, ppl_pkg::REG_CTRL, ctrl(1'b0, 3'h0, tr[i], tp[i], '0), q, nw);
      `CHK("stall", 1'b1, nw > 10)
      `CHK("pwr kept", {LANES{tp[i]}}, pwr)
      `CHK("rate kept", er, rate)
    end
    $display("test requests done");
    av(1'b0, 8'h10, 32'h0, q, nw);
    `CHK("unmapped", ppl_pkg::UNMAPPED_RD, q)
    av(1'b1, 8'h10, 32'hffffffff, q, nw);
    av(1'b0, ppl_pkg::REG_COEF, 32'h0, q, nw);
    `CHK("coef read", 18'h29c45, q[17:0])
    idle <= 2'h2;
    repeat (2) @(posedge clk_i);
    av(1'b0, ppl_pkg::REG_STATUS, 32'h0, q, nw);
    `CHK("rx idle", 2'h2, q[1:0])
    $display("test status done");
    end_sim();
  end
endmodule : pcie_pipe_mac_lane_interface_tb_top
`default_nettype wire
